// ---- pcd_countdown.sv ----
// pedestrian countdown controller: learns clearance time, drives two digits
// assumes lamp drives and supply-good arrive asynchronously from the cabinet
//
// Summary of operation
// - Only clearance countdown: load the learned time at flashing stop, count to zero, blank at steady stop.
// - After power-on learning runs with the digits dark until a cycle ends in walk or steady stop, not with both lamps dark.
// - A measured interval longer than the stored one blanks the digits and forces one silent relearn cycle; a shorter one forces it only on a repeat.
// - Back-to-back cycles with no steady stop between them are each accepted as valid cycles.
// - A walk cut short straight into flashing stop starts the countdown when flashing begins.
// - Preemption during flashing stop ends the count: the digits blank and the next walk-to-flash edge reloads it.
// - The cycle after a preemption counts from the stored value, never from the shortened one.
// - Steady stop before zero, or both lamps dark, stops timing and blanks the digits.
// - A supply loss over 1.5 s keeps the digits dark for one complete cycle.
// - The count is shown on two seven-segment digits decoded from the current value.
// - No control changes the timing; it comes only from what is learned.
`default_nettype none

module pcd_countdown #(
  parameter int unsigned MS_CYCLES = pcd_pkg::MS_CYCLES
) (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic               clkEn,
  input  wire pcd_pkg::pcd_lamps_s lamps,
  input  wire logic               pwrOk,
  output pcd_pkg::pcd_disp_s      disp
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] x);
    if (x == pcd_pkg::BCD_MAX)
      return x;
    else if (x[3:0] == 4'h9)
      return {x[7:4] + 4'h1, 4'h0};
    else
      return {x[7:4], x[3:0] + 4'h1};
  endfunction : bcd_inc

  function automatic logic [7:0] bcd_dec(input logic [7:0] x);
    if (x == 8'h00)
      return x;
    else if (x[3:0] == 4'h0)
      return {x[7:4] - 4'h1, 4'h9};
    else
      return {x[7:4], x[3:0] - 4'h1};
  endfunction : bcd_dec

  // round half up to whole seconds
  function automatic logic [7:0] round_sec(input logic [7:0] sec, input logic [9:0] sub);
    return (sub >= pcd_pkg::HALF_SEC_MS) ? bcd_inc(sec) : sec;
  endfunction : round_sec

  function automatic logic [6:0] seg7(input logic [3:0] d);
    logic [6:0] r;
    r = 7'h00;
    unique case (d)
      4'h0: r = 7'h3F;
      4'h1: r = 7'h06;
      4'h2: r = 7'h5B;
      4'h3: r = 7'h4F;
      4'h4: r = 7'h66;
      4'h5: r = 7'h6D;
      4'h6: r = 7'h7D;
      4'h7: r = 7'h07;
      4'h8: r = 7'h7F;
      4'h9: r = 7'h6F;
      default: r = 7'h00;
    endcase
    return r;
  endfunction : seg7

  function automatic logic [10:0] sat_inc(input logic [10:0] x);
    return (x == pcd_pkg::MS_SAT) ? x : x + 11'd1;
  endfunction : sat_inc

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  pcd_pkg::pcd_state_s s_r;
  pcd_pkg::pcd_state_s s_nxt;
  pcd_pkg::pcd_phase_e phaseNow;
  logic                msTick;
  logic                secTick;
  logic                flashStart;
  logic                flashEnd;
  logic [7:0]          meas;

  assign msTick = (s_r.preCnt == 16'(MS_CYCLES - 1));
  assign secTick = msTick && (s_r.subMs == pcd_pkg::SEC_MS - 10'd1) && (s_r.phase == pcd_pkg::PH_FLASH);

  // stop lit briefly or lit recently reads as flashing; both lamps lit is abnormal
  always_comb
  begin
    if (s_r.walkF && s_r.stopF)
      phaseNow = pcd_pkg::PH_DARK;
    else if (s_r.walkF)
      phaseNow = pcd_pkg::PH_WALK;
    else if (s_r.stopF && s_r.stopOnMs >= pcd_pkg::STEADY_MS)
      phaseNow = pcd_pkg::PH_STEADY;
    else if (s_r.stopF || s_r.stopIdleMs < pcd_pkg::HOLD_MS)
      phaseNow = pcd_pkg::PH_FLASH;
    else
      phaseNow = pcd_pkg::PH_DARK;
  end

  // only a walk-to-flash edge opens a cycle, so steady-to-flash flicker is ignored
  assign flashStart = (s_r.phase == pcd_pkg::PH_WALK) && (phaseNow == pcd_pkg::PH_FLASH);
  assign flashEnd = (s_r.phase == pcd_pkg::PH_FLASH) && (phaseNow != pcd_pkg::PH_FLASH);
  // steady start is detected late, so take the time of the final stop rising edge
  assign meas = (phaseNow == pcd_pkg::PH_STEADY) ? round_sec(s_r.snapSec, s_r.snapSub)
                                                 : round_sec(s_r.elapsed, s_r.subMs);

  always_comb
  begin
    s_nxt = s_r;
    // ------------------------------------------------------------------------
    // input synchronisers and filters
    // ------------------------------------------------------------------------
    s_nxt.walkSync = {s_r.walkSync[1:0], lamps.walk};
    s_nxt.stopSync = {s_r.stopSync[1:0], lamps.stop};
    s_nxt.pwrSync = {s_r.pwrSync[1:0], pwrOk};
    if (s_r.walkSync[1] == s_r.walkSync[2])
      s_nxt.walkF = s_r.walkSync[2];
    if (s_r.stopSync[1] == s_r.stopSync[2])
      s_nxt.stopF = s_r.stopSync[2];
    if (s_r.pwrSync[1] == s_r.pwrSync[2])
      s_nxt.pwrF = s_r.pwrSync[2];

    s_nxt.preCnt = msTick ? 16'h0000 : s_r.preCnt + 16'h0001;
    if (!s_r.stopF)
      s_nxt.stopOnMs = 11'h000;
    else if (msTick)
      s_nxt.stopOnMs = sat_inc(s_r.stopOnMs);
    if (s_r.stopF)
      s_nxt.stopIdleMs = 11'h000;
    else if (msTick)
      s_nxt.stopIdleMs = sat_inc(s_r.stopIdleMs);
    s_nxt.phase = phaseNow;

    // ------------------------------------------------------------------------
    // clearance timing
    // ------------------------------------------------------------------------
    if (flashStart)
    begin
      s_nxt.subMs = 10'h000;
      s_nxt.elapsed = 8'h00;
      s_nxt.snapSec = 8'h00;
      s_nxt.snapSub = 10'h000;
      s_nxt.count = s_r.stored;
      s_nxt.counting = (s_r.mode == pcd_pkg::MD_RUN) && s_r.pwrF;
    end
    else if (s_r.phase == pcd_pkg::PH_FLASH)
    begin
      if (s_nxt.stopF && !s_r.stopF)
      begin
        s_nxt.snapSec = s_r.elapsed;
        s_nxt.snapSub = s_r.subMs;
      end
      if (secTick)
      begin
        s_nxt.subMs = 10'h000;
        s_nxt.elapsed = bcd_inc(s_r.elapsed);
        s_nxt.count = bcd_dec(s_r.count);
      end
      else if (msTick)
        s_nxt.subMs = s_r.subMs + 10'h001;
      // running past the stored time means the timing grew; blank now,
      // relearn is armed at flash end so the next cycle is the silent one
      if (s_r.counting && s_r.elapsed > s_r.stored)
        s_nxt.counting = 1'b0;
    end

    if (flashEnd)
    begin
      s_nxt.counting = 1'b0;
      if (phaseNow != pcd_pkg::PH_DARK)
      begin
        if (s_r.mode == pcd_pkg::MD_LEARN)
        begin
          s_nxt.stored = meas;
          s_nxt.mode = pcd_pkg::MD_RUN;
          s_nxt.shortSeen = 1'b0;
        end
        else if (meas > s_r.stored)
          s_nxt.mode = pcd_pkg::MD_LEARN;
        else if (meas < s_r.stored)
        begin
          // a single short cycle is taken as preemption; a repeat is a real change
          if (s_r.shortSeen && meas == s_r.shortVal)
          begin
            s_nxt.mode = pcd_pkg::MD_LEARN;
            s_nxt.shortSeen = 1'b0;
          end
          else
          begin
            s_nxt.shortSeen = 1'b1;
            s_nxt.shortVal = meas;
          end
        end
        else
          s_nxt.shortSeen = 1'b0;
      end
    end
    else if (phaseNow == pcd_pkg::PH_STEADY || phaseNow == pcd_pkg::PH_DARK)
      s_nxt.counting = 1'b0;

    // ------------------------------------------------------------------------
    // supply monitor
    // ------------------------------------------------------------------------
    if (s_r.pwrF)
      s_nxt.lossMs = 11'h000;
    else
    begin
      s_nxt.counting = 1'b0;
      if (msTick)
        s_nxt.lossMs = sat_inc(s_r.lossMs);
      if (s_r.lossMs >= pcd_pkg::PWR_LOSS_MS)
        s_nxt.mode = pcd_pkg::MD_LEARN;
    end

    // ------------------------------------------------------------------------
    // display
    // ------------------------------------------------------------------------
    s_nxt.disp.on = s_nxt.counting;
    s_nxt.disp.tens = s_nxt.counting ? seg7(s_nxt.count[7:4]) : 7'h00;
    s_nxt.disp.ones = s_nxt.counting ? seg7(s_nxt.count[3:0]) : 7'h00;
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_r <= pcd_pkg::RESET_STATE;
    else if (clkEn)
      s_r <= s_nxt;
  end

  assign disp = s_r.disp;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  a_learn_dark: assert property (s_r.mode == pcd_pkg::MD_LEARN |-> !disp.on)
    else $error("digits lit during learning");

  a_load_flash: assert property (clkEn && flashStart && s_r.mode == pcd_pkg::MD_RUN && s_r.pwrF
                                 |=> s_r.counting && s_r.count == $past(s_r.stored))
    else $error("countdown not loaded at flash start");

  a_no_reload: assert property (clkEn && s_r.counting && s_r.phase == pcd_pkg::PH_FLASH && !secTick
                                && phaseNow == pcd_pkg::PH_FLASH |=> s_r.count == $past(s_r.count))
    else $error("count changed without a second tick");

  a_tick_dec: assert property (clkEn && secTick && s_r.counting && phaseNow == pcd_pkg::PH_FLASH
                               |=> s_r.count == bcd_dec($past(s_r.count)))
    else $error("count not decremented on second tick");

  a_steady_blank: assert property (clkEn && (phaseNow == pcd_pkg::PH_STEADY || phaseNow == pcd_pkg::PH_DARK)
                                   |=> !s_r.counting ##1 !disp.on)
    else $error("digits not blanked on steady or dark");

  a_power_loss: assert property (clkEn && !s_r.pwrF && s_r.lossMs >= pcd_pkg::PWR_LOSS_MS
                                 |=> s_r.mode == pcd_pkg::MD_LEARN)
    else $error("long supply loss did not force relearn");

  a_seg_tens: assert property (disp.on |-> disp.tens == seg7(s_r.count[7:4]) && s_r.count[7:4] <= 4'h9)
    else $error("tens digit does not match count");

  a_keep_stored: assert property (clkEn && flashEnd && s_r.mode == pcd_pkg::MD_RUN && meas < s_r.stored
                                  && !s_r.shortSeen |=> s_r.stored == $past(s_r.stored)
                                  && s_r.mode == pcd_pkg::MD_RUN)
    else $error("preempted cycle replaced stored time");

  a_grow_relearn: assert property (clkEn && flashEnd && s_r.mode == pcd_pkg::MD_RUN
                                   && phaseNow != pcd_pkg::PH_DARK && meas > s_r.stored
                                   |=> s_r.mode == pcd_pkg::MD_LEARN ##1 !disp.on)
    else $error("longer interval did not force relearn");

  a_walk_filter: assert property (clkEn && s_r.walkSync[1] != s_r.walkSync[2] |=> s_r.walkF == $past(s_r.walkF))
    else $error("walk filter took a disagreeing sample");

endmodule : pcd_countdown

`default_nettype wire

// ---- pcd_countdown_tb_top.sv ----
// self-checking bench for the pedestrian countdown controller
// assumes MS_CYCLES shortened to 2, so one second is 2000 clocks
`default_nettype none

module pcd_countdown_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // --------------------------------------------------------------------------
  // set-up
  // --------------------------------------------------------------------------
  localparam int unsigned MSC  = 2;
  // segments bit0=a .. bit6=g
  localparam logic [6:0]  SEG0 = 7'h3F;
  localparam logic [6:0]  SEG1 = 7'h06;
  localparam logic [6:0]  SEG2 = 7'h5B;
  localparam logic [6:0]  SEG3 = 7'h4F;
  localparam logic [6:0]  SEG5 = 7'h6D;

  logic                sys_clk;
  logic                sys_rst;
  logic                pwrOk;
  logic                litSeen;
  int                  failCount;
  int                  comparisons;
  wire pcd_pkg::pcd_lamps_s lamps;
  wire pcd_pkg::pcd_disp_s  disp;

  pcd_countdown #(.MS_CYCLES(MSC)) i_pcd_countdown (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .clkEn   (1'b1),
    .lamps   (lamps),
    .pwrOk   (pwrOk),
    .disp    (disp)
  );

  pcd_lamp_ctrl #(.MS_CYCLES(MSC)) i_pcd_lamp_ctrl (
    .sys_clk (sys_clk),
    .lamps   (lamps)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // any lit digit during a silent cycle is remembered here
  always @(posedge sys_clk)
    if (disp.on === 1'b1)
      litSeen <= 1'b1;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  task automatic wait_ms(input int n);
    repeat (n * MSC) @(posedge sys_clk);
    #2;
  endtask : wait_ms

  task automatic check(input string what, input logic [14:0] exp, input logic [14:0] seen);
    comparisons++;
    if (seen !== exp)
    begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [14:0] lit(input logic [6:0] t, input logic [6:0] o);
    return {1'b1, t, o};
  endfunction : lit

  task automatic silent_cycle(input string what, input int flashMs);
    litSeen = 1'b0;
    i_pcd_lamp_ctrl.run_cycle(300, flashMs, 0);
    check(what, 15'h0000, {14'h0000, litSeen});
  endtask : silent_cycle

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic count_down();
    fork
      i_pcd_lamp_ctrl.run_cycle(300, 3000, 0);
      begin
        wait_ms(500);
        check("count 3", lit(SEG0, SEG3), disp);
        wait_ms(1000);
        check("count 2", lit(SEG0, SEG2), disp);
        wait_ms(1000);
        check("count 1", lit(SEG0, SEG1), disp);
      end
    join
  endtask : count_down

  task automatic preempt();
    fork
      i_pcd_lamp_ctrl.run_cycle(100, 1000, 0);
      begin
        wait_ms(300);
        check("preempted start", lit(SEG0, SEG3), disp);
        wait_ms(700);
        check("preempted run", lit(SEG0, SEG3), disp);
      end
    join
    fork
      i_pcd_lamp_ctrl.run_cycle(300, 3000, 0);
      begin
        wait_ms(500);
        check("after preempt", lit(SEG0, SEG3), disp);
      end
    join
  endtask : preempt

  task automatic early_steady();
    fork
      i_pcd_lamp_ctrl.run_cycle(300, 1000, 1);
      begin
        wait_ms(500);
        check("before steady", lit(SEG0, SEG3), disp);
      end
    join
    wait_ms(1800);
    check("steady early", 15'h0000, disp);
  endtask : early_steady

  task automatic power_loss();
    pwrOk = 1'b0;
    wait_ms(2000);
    pwrOk = 1'b1;
    wait_ms(100);
    silent_cycle("after loss", 3000);
  endtask : power_loss

  task automatic longer_timing();
    fork
      i_pcd_lamp_ctrl.run_cycle(300, 5000, 0);
      begin
        wait_ms(500);
        check("old timing", lit(SEG0, SEG3), disp);
        wait_ms(4300);
        check("overrun blank", 15'h0000, disp);
      end
    join
    silent_cycle("relearn", 5000);
    fork
      i_pcd_lamp_ctrl.run_cycle(300, 1000, 0);
      begin
        wait_ms(500);
        check("new timing", lit(SEG0, SEG5), disp);
      end
    join
  endtask : longer_timing

  // --------------------------------------------------------------------------
  // run control
  // --------------------------------------------------------------------------
  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrapUp

  // about 63000 clocks expected; cut off well beyond
  initial
  begin
    #(90000 * 25);
    failCount++;
    wrapUp();
  end

  initial
  begin
    sys_rst = 1'b1;
    pwrOk = 1'b1;
    litSeen = 1'b0;
    failCount = 0;
    comparisons = 0;
    repeat (3) @(posedge sys_clk);
    #2;
    sys_rst = 1'b0;
    silent_cycle("learning", 3000);
    count_down();
    preempt();
    early_steady();
    power_loss();
    longer_timing();
    wrapUp();
  end

endmodule : pcd_countdown_tb_top

`default_nettype wire

// ---- pcd_lamp_ctrl.sv ----
// model of the signal controller's pedestrian lamp drives
// assumes the bench calls run_cycle; drives change 2 ns after a clock edge
`default_nettype none

module pcd_lamp_ctrl #(
  parameter int unsigned MS_CYCLES = 2
) (
  input  wire logic              sys_clk,
  output var pcd_pkg::pcd_lamps_s lamps
);
  timeunit 1ns;
  timeprecision 100ps;

  // --------------------------------------------------------------------------
  // lamp sequencing
  // --------------------------------------------------------------------------
  initial lamps = '0;

  task automatic wait_ms(input int n);
    repeat (n * MS_CYCLES) @(posedge sys_clk);
    #2;
  endtask : wait_ms

  // walk, then stop lamp 500 ms on / 500 ms off; end 0 leaves it for a
  // back-to-back walk, 1 makes it steady, 2 leaves both lamps dark
  task automatic run_cycle(input int walkMs, input int flashMs, input int endMode);
    int t;
    lamps = '{walk: 1'b1, stop: 1'b0};
    wait_ms(walkMs);
    for (t = 0; t < flashMs; t += 500)
    begin
      lamps = '{walk: 1'b0, stop: ((t % 1000) == 0)};
      wait_ms(500);
    end
    if (endMode == 1)
      lamps.stop = 1'b1;
    if (endMode == 2)
      lamps.stop = 1'b0;
  endtask : run_cycle

endmodule : pcd_lamp_ctrl

`default_nettype wire

// ---- pcd_pkg.sv ----
// constants, state and carrier types for the pedestrian countdown controller
// assumes a single 40 MHz clock and a power-on reset from the supply monitor
`default_nettype none

package pcd_pkg;

  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 40000000;
  localparam int unsigned TICK_MS     = 1;
  localparam int unsigned MS_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam logic [9:0]  SEC_MS      = 10'd1000;
  localparam logic [9:0]  HALF_SEC_MS = 10'd500;
  localparam logic [10:0] STEADY_MS   = 11'd1500;
  localparam logic [10:0] HOLD_MS     = 11'd1500;
  localparam logic [10:0] PWR_LOSS_MS = 11'd1500;
  localparam logic [10:0] MS_SAT      = 11'h7FF;
  localparam logic [7:0]  BCD_MAX     = 8'h99;

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_DARK   = 2'b00,
    PH_WALK   = 2'b01,
    PH_FLASH  = 2'b10,
    PH_STEADY = 2'b11
  } pcd_phase_e;

  typedef enum logic {
    MD_LEARN = 1'b0,
    MD_RUN   = 1'b1
  } pcd_mode_e;

  typedef struct packed {
    logic walk;
    logic stop;
  } pcd_lamps_s;

  typedef struct packed {
    logic       on;
    logic [6:0] tens;
    logic [6:0] ones;
  } pcd_disp_s;

  typedef struct packed {
    logic [2:0]  walkSync;
    logic [2:0]  stopSync;
    logic [2:0]  pwrSync;
    logic        walkF;
    logic        stopF;
    logic        pwrF;
    logic [15:0] preCnt;
    logic [10:0] stopOnMs;
    logic [10:0] stopIdleMs;
    logic [10:0] lossMs;
    pcd_phase_e  phase;
    pcd_mode_e   mode;
    logic        counting;
    logic [9:0]  subMs;
    logic [7:0]  elapsed;
    logic [7:0]  snapSec;
    logic [9:0]  snapSub;
    logic [7:0]  count;
    logic [7:0]  stored;
    logic        shortSeen;
    logic [7:0]  shortVal;
    pcd_disp_s   disp;
  } pcd_state_s;

  // idle timer starts saturated, else reset would read as a flashing stop
  localparam pcd_state_s RESET_STATE = '{phase: PH_DARK, mode: MD_LEARN, stopIdleMs: MS_SAT, default: '0};

endpackage : pcd_pkg

`default_nettype wire
